// ===== hw/frt_capt_chan.sv
// one capture channel: synchroniser, edge select, latch, request flag
`timescale 1ns/1ps
module frt_capt_chan
  import frt_pkg::*;
#(
  parameter int CNT_W = FRT_CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // pin and timebase
  input wire logic pin,
  input wire logic [CNT_W-1:0] count,
  // control
  input wire logic [1:0] edge_sel,
  input wire logic flag_clr,
  // results
  output logic [CNT_W-1:0] capt_reg,
  output logic flag_reg
);
  logic sync1_reg, sync2_reg, prev_reg;
  wire rise = sync2_reg & ~prev_reg;
  wire fall = ~sync2_reg & prev_reg;
  wire hit = (edge_sel[0] & rise) | (edge_sel[1] & fall);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      capt_reg <= '0;
      flag_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      if (hit) begin
        capt_reg <= count;
      end
      // a new edge wins over a clear in the same cycle
      flag_reg <= hit | (flag_reg & ~flag_clr);
    end
  end
  cap_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hit |=> capt_reg == $past(count)) else $error("capture missed count");
  flag_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && hit |=> flag_reg) else $error("capture flag not set");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && flag_clr && !hit |=> !flag_reg) else $error("capture flag not cleared");
endmodule : frt_capt_chan

// ===== hw/frt_pkg.sv
// package: register map, fields and reset values of the free-run timer with capture
package frt_pkg;
  localparam int FRT_CNT_W = 16;
  localparam int FRT_NCH = 4;
  localparam int FRT_ADR_W = 4;
  // word byte addresses on the wishbone bus
  localparam logic [FRT_ADR_W-1:0] FRT_OFS_COUNT = 4'h0;
  localparam logic [FRT_ADR_W-1:0] FRT_OFS_CTRL = 4'h4;
  localparam logic [FRT_ADR_W-1:0] FRT_OFS_EDGE = 4'h8;
  localparam logic [FRT_ADR_W-1:0] FRT_OFS_FLAG = 4'hC;
  // capture values sit in a separate window, one word per channel
  localparam logic [5:0] FRT_OFS_CAPT = 6'h10;
  // control register fields
  localparam int FRT_CTRL_DIV_LSB = 0;
  localparam int FRT_CTRL_STOP = 2;
  localparam int FRT_CTRL_CLR = 3;
  localparam int FRT_CTRL_OVF = 4;
  localparam int FRT_CTRL_OVIE = 5;
  localparam logic [7:0] FRT_CTRL_RST = 8'h00;
  // prescaler terminal counts for the four ratios (1,4,16,64 machine cycles)
  localparam logic [5:0] FRT_DIV_CODE [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};
  // edge selects: 2 bits per channel, 0 off, 1 rising, 2 falling, 3 both
  localparam logic [1:0] FRT_EDGE_OFF = 2'h0;
  localparam logic [1:0] FRT_EDGE_RISE = 2'h1;
  localparam logic [1:0] FRT_EDGE_FALL = 2'h2;
  localparam logic [1:0] FRT_EDGE_BOTH = 2'h3;
  localparam logic [7:0] FRT_IRQ_TIMER_NUM = 8'h13;
endpackage : frt_pkg

// ===== hw/frt_timer.sv
// free-run 16-bit timer with prescaler and four input capture channels
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module frt_timer
  import frt_pkg::*;
#(
  parameter int CNT_W = FRT_CNT_W,
  parameter int NCH = FRT_NCH
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // capture trigger pins
  input wire logic [NCH-1:0] capture_trigger_pins,
  // interrupt requests
  output logic timer_irq_reg,
  output logic [NCH-1:0] capt_irq_reg,
  output logic [7:0] timer_irq_num_reg
);
  if (CNT_W < 2 || CNT_W > 32 || NCH < 1 || NCH > 4) begin : g_bad_param
    $error("frt_timer: unsupported parameters");
  end

  logic [CNT_W-1:0] free_run_count_value;
  logic [7:0] counter_control_status_register;
  logic [2*NCH-1:0] edge_reg;
  logic [NCH-1:0] capt_ie_reg;
  logic [5:0] pre_reg;
  logic [CNT_W-1:0] capt_val [NCH];
  logic [NCH-1:0] capt_flag;

  // register map, one 32-bit word each, offsets from the package:
  //   count word: present counter value, loadable only while stopped
  //   control word: prescale select, stop, one-shot clear, overflow flag and its enable
  //   edge word: two edge-select bits per channel, capture request enables above them
  //   flag word: capture flags, a one written clears, a new edge wins over the clear
  //   capture window: one read-only word per channel with the latched count
  // every access is answered after one cycle, unmapped ones included
  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire wr_lo = req & wb_we_i;
  wire sel_count = wb_adr_i == {2'b00, FRT_OFS_COUNT};
  wire sel_ctrl = wb_adr_i == {2'b00, FRT_OFS_CTRL};
  wire sel_edge = wb_adr_i == {2'b00, FRT_OFS_EDGE};
  wire sel_flag = wb_adr_i == {2'b00, FRT_OFS_FLAG};
  wire sel_capt = wb_adr_i[5:4] == FRT_OFS_CAPT[5:4] && wb_adr_i[1:0] == 2'b00;
  wire [1:0] capt_idx = wb_adr_i[3:2];

  wire stopped = counter_control_status_register[FRT_CTRL_STOP];
  wire [1:0] div_sel = counter_control_status_register[FRT_CTRL_DIV_LSB +: 2];
  // >= lets a ratio lowered while running tick at once instead of running the prescaler round
  wire tick = ~stopped & (pre_reg >= FRT_DIV_CODE[div_sel]);
  wire wrap = tick & (&free_run_count_value);
  wire load_cnt = wr_lo & sel_count & stopped & (&wb_sel_i[1:0]);
  wire clr_cnt = wr & sel_ctrl & wb_dat_i[FRT_CTRL_CLR];
  wire ovf_clr = wr & sel_ctrl & ~wb_dat_i[FRT_CTRL_OVF];
  wire [NCH-1:0] flag_clr = (wr & sel_flag) ? wb_dat_i[NCH-1:0] : '0;

  // count register: load, clear, or tick with natural wrap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      free_run_count_value <= '0;
      pre_reg <= '0;
    end else if (clk_en) begin
      pre_reg <= (tick || stopped) ? 6'h00 : pre_reg + 6'h01;
      if (load_cnt) begin
        free_run_count_value <= wb_dat_i[CNT_W-1:0];
      end else if (clr_cnt) begin
        free_run_count_value <= '0;
      end else if (tick) begin
        free_run_count_value <= free_run_count_value + 1'b1;
      end
    end
  end

  // control: divider, stop, overflow flag (set wins over clear), overflow enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      counter_control_status_register <= FRT_CTRL_RST;
      edge_reg <= '0;
      capt_ie_reg <= '0;
    end else if (clk_en) begin
      if (wr & sel_ctrl) begin
        counter_control_status_register[FRT_CTRL_DIV_LSB +: 2] <= wb_dat_i[FRT_CTRL_DIV_LSB +: 2];
        counter_control_status_register[FRT_CTRL_STOP] <= wb_dat_i[FRT_CTRL_STOP];
        counter_control_status_register[FRT_CTRL_OVIE] <= wb_dat_i[FRT_CTRL_OVIE];
      end
      counter_control_status_register[FRT_CTRL_OVF] <= wrap |
        (counter_control_status_register[FRT_CTRL_OVF] & ~ovf_clr);
      if (wr & sel_edge) begin
        edge_reg <= wb_dat_i[2*NCH-1:0];
        capt_ie_reg <= wb_dat_i[8 +: NCH];
      end
    end
  end

  // capture channels, one per trigger pin
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      frt_capt_chan #(.CNT_W(CNT_W)) u_ch (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .pin(capture_trigger_pins[gi]),
        .count(free_run_count_value),
        .edge_sel(edge_reg[2*gi +: 2]),
        .flag_clr(flag_clr[gi]),
        .capt_reg(capt_val[gi]),
        .flag_reg(capt_flag[gi])
      );
    end
  endgenerate

  // read mux
  wire [31:0] rd_count = 32'(free_run_count_value);
  wire [31:0] rd_ctrl = 32'(counter_control_status_register);
  wire [31:0] rd_edge = (32'(capt_ie_reg) << 8) | 32'(edge_reg);
  wire [31:0] rd_flag = 32'(capt_flag);
  wire capt_ok = sel_capt && (capt_idx < NCH);
  wire [31:0] rd_capt = capt_ok ? 32'(capt_val[capt_idx]) : 32'h00000000;
  wire [31:0] rd_data = sel_count ? rd_count :
                        sel_ctrl ? rd_ctrl :
                        sel_edge ? rd_edge :
                        sel_flag ? rd_flag : rd_capt;

  // one wait-free answer: ack the cycle after the request, unmapped reads give zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      timer_irq_reg <= 1'b0;
      capt_irq_reg <= '0;
      timer_irq_num_reg <= 8'h00;
    end else if (clk_en) begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_data : 32'h00000000;
      timer_irq_reg <= counter_control_status_register[FRT_CTRL_OVF] &
        counter_control_status_register[FRT_CTRL_OVIE];
      capt_irq_reg <= capt_flag & capt_ie_reg;
      timer_irq_num_reg <= FRT_IRQ_TIMER_NUM;
    end
  end

  // a write while running must not disturb the counting
  load_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && wr_lo && sel_count && !stopped && !clr_cnt && !tick
    |=> free_run_count_value == $past(free_run_count_value)) else $error("load while running");
  load_val_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && load_cnt |=> free_run_count_value == $past(wb_dat_i[CNT_W-1:0])) else $error("load lost");
  stop_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && stopped && !load_cnt && !clr_cnt
    |=> free_run_count_value == $past(free_run_count_value)) else $error("count moved while stopped");
  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && clr_cnt && !load_cnt |=> free_run_count_value == '0) else $error("clear lost");
  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !clk_en |=> free_run_count_value == $past(free_run_count_value) && wb_ack_o == $past(wb_ack_o))
    else $error("state moved while frozen");
  count_inc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && tick && !load_cnt && !clr_cnt
    |=> free_run_count_value == $past(free_run_count_value) + 1'b1) else $error("tick lost");
  wrap_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && wrap && !load_cnt && !clr_cnt
    |=> free_run_count_value == '0 && counter_control_status_register[FRT_CTRL_OVF]) else $error("no wrap");
  ovf_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && ovf_clr && !wrap |=> !counter_control_status_register[FRT_CTRL_OVF]) else $error("overflow kept");
  div_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !stopped && div_sel == 2'h0 |-> tick) else $error("ratio one not ticking");
  pre_rst_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && stopped |=> pre_reg == '0) else $error("prescaler not reset");

  // bus answers
  read_cnt_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && req && !wb_we_i && sel_count |=> wb_ack_o && wb_dat_o == $past(rd_count)) else $error("count read");
  read_none_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && req && !wb_we_i && !sel_count && !sel_ctrl && !sel_edge && !sel_flag && !capt_ok
    |=> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && wb_ack_o |=> !wb_ack_o) else $error("ack held");
  flag_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && req && !wb_we_i && sel_flag |=> wb_dat_o[NCH-1:0] == $past(capt_flag)) else $error("flag read");

  // interrupts and capture
  capt_irq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && capt_flag[0] && capt_ie_reg[0] |=> capt_irq_reg[0]) else $error("capture irq missing");
  for (gi = 0; gi < NCH; gi++) begin : g_irq_chk
    chan_irq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en |=> capt_irq_reg[gi] == $past(capt_flag[gi] & capt_ie_reg[gi])) else $error("channel irq level");
  end
  timer_irq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en |=> timer_irq_reg == $past(counter_control_status_register[FRT_CTRL_OVF] &
    counter_control_status_register[FRT_CTRL_OVIE])) else $error("timer irq level");
  irq_num_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en |=> timer_irq_num_reg == FRT_IRQ_TIMER_NUM) else $error("irq number");
  edge_wr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && wr && sel_edge |=> edge_reg == $past(wb_dat_i[2*NCH-1:0])) else $error("edge select lost");
  chan_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && edge_reg[2*(NCH-1) +: 2] == FRT_EDGE_OFF && !capt_flag[NCH-1]
    |=> !capt_flag[NCH-1]) else $error("disabled channel captured");

  cov_freeze: cover property (@(posedge sys_clk) disable iff (!nrst) !clk_en ##1 clk_en);
  cov_wrap: cover property (@(posedge sys_clk) disable iff (!nrst) wrap);
  cov_capt: cover property (@(posedge sys_clk) disable iff (!nrst) capt_flag[0] && capt_ie_reg[0]);
  cov_load: cover property (@(posedge sys_clk) disable iff (!nrst) load_cnt);
  cov_div3: cover property (@(posedge sys_clk) disable iff (!nrst) tick && div_sel == 2'h3);
endmodule : frt_timer

// ===== tb/frt_pin_model.sv
// partner model: drives the four capture trigger pins, promptly or one cycle late
`timescale 1ns/1ps
module frt_pin_model (
  // clock
  input wire logic sys_clk,
  // requested levels and pace
  input wire logic [3:0] want,
  input wire logic slow,
  // pins toward the timer
  output logic [3:0] pins = 4'h0
);
  logic [3:0] late_reg = 4'h0;
  // the pins are only ever driven toward the timer, so they act as plain inputs there
  always @(posedge sys_clk) begin
    late_reg <= want;
    pins <= slow ? late_reg : want;
  end
endmodule : frt_pin_model

// ===== tb/tb_top.sv
// testbench: registers, prescaler, wrap and capture of the free-run timer
`timescale 1ns/1ps
module tb_top;
  import frt_pkg::*;
  typedef struct {logic we; logic [5:0] adr; logic [31:0] dat;} frt_row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic en = 1'b1;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, tirq;
  logic [3:0] want = 4'h0;
  logic [3:0] pins, cirq;
  logic [7:0] inum;
  int fail_count = 0;
  int compares = 0;
  // reads carry the expected value in dat, writes the data to write
  frt_row_t rows [9] = '{
    '{1'b0, 6'h04, 32'h0},
    '{1'b1, 6'h04, 32'h4},
    '{1'b1, 6'h00, 32'hFFFE},
    '{1'b0, 6'h00, 32'hFFFE},
    '{1'b1, 6'h08, 32'hF39},
    '{1'b0, 6'h08, 32'hF39},
    '{1'b1, 6'h30, 32'h5A},
    '{1'b0, 6'h30, 32'h0},
    '{1'b0, 6'h20, 32'h0}};

  always #5 sys_clk = ~sys_clk;

  frt_timer u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .capture_trigger_pins(pins), .timer_irq_reg(tirq), .capt_irq_reg(cirq), .timer_irq_num_reg(inum));
  frt_pin_model u_pins (.sys_clk(sys_clk), .want(want), .slow(slow), .pins(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ack is a registered flop, so its value before the edge is the one sampled here
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    #12 check({24'h0, inum}, 32'h0);
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].we) xfer(1'b1, rows[i].adr, rows[i].dat);
      else rd(rows[i].adr, rows[i].dat);
    end
    check({24'h0, inum}, {24'h0, FRT_IRQ_TIMER_NUM});
    // run from all ones minus one with the overflow request enabled
    xfer(1'b1, 6'h04, 32'h20);
    repeat (8) @(posedge sys_clk);
    rd(6'h04, 32'h30);
    check({31'h0, tirq}, 32'h1);
    xfer(1'b1, 6'h00, 32'hABCD);
    xfer(1'b0, 6'h00, 32'h0);
    check({31'h0, rdat < 32'h40}, 32'h1);
    xfer(1'b1, 6'h04, 32'h20);
    repeat (3) @(posedge sys_clk);
    check({31'h0, tirq}, 32'h0);
    // with one-cycle answers the run lasts 259 edges from the start write to the stop write
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 6'h04, 32'h4 | s);
      xfer(1'b1, 6'h00, 32'h0);
      xfer(1'b1, 6'h04, s);
      repeat (256) @(posedge sys_clk);
      xfer(1'b1, 6'h04, 32'h4 | s);
      xfer(1'b0, 6'h00, 32'h0);
      check(rdat, 32'(259 >> 2*s));
    end
    // counter halted so captured values are exact
    xfer(1'b1, 6'h00, 32'h100);
    want <= 4'hF;
    repeat (8) @(posedge sys_clk);
    rd(6'h0C, 32'h5);
    check({28'h0, cirq}, 32'h5);
    rd(6'h10, 32'h100);
    rd(6'h18, 32'h100);
    rd(6'h1C, 32'h0);
    xfer(1'b1, 6'h0C, 32'hF);
    xfer(1'b1, 6'h00, 32'h200);
    slow <= 1'b1;
    want <= 4'h0;
    repeat (9) @(posedge sys_clk);
    rd(6'h0C, 32'h6);
    check({28'h0, cirq}, 32'h6);
    rd(6'h14, 32'h200);
    rd(6'h18, 32'h200);
    rd(6'h10, 32'h100);
    // one-shot clear, then a 20-cycle clock-enable freeze with the counter running at ratio one
    xfer(1'b1, 6'h04, 32'hF);
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h7);
    xfer(1'b1, 6'h00, 32'h10);
    xfer(1'b1, 6'h04, 32'h0);
    en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    en <= 1'b1;
    xfer(1'b1, 6'h04, 32'h4);
    rd(6'h00, 32'h13);
    // a reset in mid-run returns outputs and registers to their reset values
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    check({24'h0, inum}, 32'h0);
    check({28'h0, cirq}, 32'h0);
    nrst <= 1'b1;
    rd(6'h04, 32'h0);
    rd(6'h0C, 32'h0);
    final_report();
  end
endmodule : tb_top
